// file: rtl/scwg_gate.sv
// command source gate: terminals or masked serial command word
// assumes terminal pins are asynchronous; the parameter port is on mclk_i
`timescale 1ns/1ps
module scwg_gate #(
	parameter int unsigned WDOG_CYCLES = scwg_pkg::SCWG_WDOG_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [6:0] term_pins_i,
	input wire logic wr_en_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [14:0] wr_data_i,
	input wire logic [2:0] rd_idx_i,
	output logic [14:0] rd_data_o,
	output logic drive_enable_o,
	output logic run_fwd_o,
	output logic run_rev_o,
	output logic jog_o,
	output logic wdog_trip_o
);

	// ****************************************************
	// declarations
	// ****************************************************
	logic stop_release; // stop-release command bit
	logic latch_en; // run latch enable
	logic [14:0] mask; // function mask, volatile
	logic [14:0] word; // serial command word
	logic select; // 1: command word has control
	logic [6:0] pin_s1; // first sync stage, read only by pin_s2
	logic [6:0] pin_s2; // synchronised terminals
	logic [31:0] wd_cnt; // watchdog age in cycles
	logic eff_en, eff_fwd, eff_jog, eff_rev, eff_dir, eff_run, eff_ns;
	logic lat_fwd, lat_rev, lat_run; // latch outputs
	logic wr_word, wd_armed, wd_refresh, seq_fwd, seq_rev, go_ok;

	// choose the word bit when the word owns this function, else fallback
	function automatic logic pick(input logic sel, input logic [14:0] m,
		input logic [14:0] w, input int idx, input logic fallback);
		pick = (sel && m[idx]) ? w[idx] : fallback;
	endfunction

	// ****************************************************
	// terminal synchroniser
	// ****************************************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
		end else if (ce_i) begin
			pin_s1 <= term_pins_i;
			pin_s2 <= pin_s1;
		end
	end

	// ****************************************************
	// parameter registers
	// ****************************************************
	// all registers clear at power-up, nothing is retained
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stop_release <= scwg_pkg::SCWG_RST_BIT;
			latch_en <= scwg_pkg::SCWG_RST_BIT;
			mask <= scwg_pkg::SCWG_RST_WORD;
			word <= scwg_pkg::SCWG_RST_WORD;
			select <= scwg_pkg::SCWG_RST_BIT;
		end else if (ce_i && wr_en_i) begin
			unique case (wr_idx_i)
				scwg_pkg::SCWG_IDX_STOP_REL: begin
					stop_release <= wr_data_i[0];
				end
				scwg_pkg::SCWG_IDX_LATCH_EN: begin
					latch_en <= wr_data_i[0];
				end
				scwg_pkg::SCWG_IDX_MASK: begin
					// reserved bits stored as zero
					mask <= wr_data_i & scwg_pkg::SCWG_WORD_USED;
				end
				scwg_pkg::SCWG_IDX_WORD: begin
					word <= wr_data_i & scwg_pkg::SCWG_WORD_USED;
				end
				scwg_pkg::SCWG_IDX_SELECT: begin
					select <= wr_data_i[0];
				end
				default: begin
					// status and unused indices ignore writes
				end
			endcase
		end
	end

	// registered read-back, unused indices read zero
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= 15'h0000;
		end else if (ce_i) begin
			unique case (rd_idx_i)
				scwg_pkg::SCWG_IDX_STOP_REL: rd_data_o <= {14'h0000, stop_release};
				scwg_pkg::SCWG_IDX_LATCH_EN: rd_data_o <= {14'h0000, latch_en};
				scwg_pkg::SCWG_IDX_MASK: rd_data_o <= mask;
				scwg_pkg::SCWG_IDX_WORD: rd_data_o <= word;
				scwg_pkg::SCWG_IDX_SELECT: rd_data_o <= {14'h0000, select};
				scwg_pkg::SCWG_IDX_STATUS: rd_data_o <= {10'h000, wdog_trip_o,
					jog_o, run_rev_o, run_fwd_o, drive_enable_o};
				default: rd_data_o <= 15'h0000;
			endcase
		end
	end

	// ****************************************************
	// source selection
	// ****************************************************
	// word bits count only for masked functions with select set
	always_comb begin
		eff_en = pick(select, mask, word, scwg_pkg::SCWG_BIT_EN,
			pin_s2[scwg_pkg::SCWG_PIN_EN]);
		eff_fwd = pick(select, mask, word, scwg_pkg::SCWG_BIT_FWD,
			pin_s2[scwg_pkg::SCWG_PIN_FWD]);
		eff_jog = pick(select, mask, word, scwg_pkg::SCWG_BIT_JOG,
			pin_s2[scwg_pkg::SCWG_PIN_JOG]);
		eff_rev = pick(select, mask, word, scwg_pkg::SCWG_BIT_REV,
			pin_s2[scwg_pkg::SCWG_PIN_REV]);
		eff_dir = pick(select, mask, word, scwg_pkg::SCWG_BIT_DIR,
			pin_s2[scwg_pkg::SCWG_PIN_DIR]);
		eff_run = pick(select, mask, word, scwg_pkg::SCWG_BIT_RUN,
			pin_s2[scwg_pkg::SCWG_PIN_RUN]);
		// stop release from the word, else the command bit
		eff_ns = pick(select, mask, word, scwg_pkg::SCWG_BIT_NSTOP,
			stop_release);
	end

	// ****************************************************
	// run latches
	// ****************************************************
	scwg_run_latch u_latch (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.latch_en_i(latch_en),
		.not_stop_i(eff_ns),
		.fwd_i(eff_fwd),
		.rev_i(eff_rev),
		.run_i(eff_run),
		.fwd_o(lat_fwd),
		.rev_o(lat_rev),
		.run_o(lat_run)
	);

	// ****************************************************
	// watchdog
	// ****************************************************
	assign wr_word = wr_en_i && (wr_idx_i == scwg_pkg::SCWG_IDX_WORD);
	assign wd_armed = select && mask[scwg_pkg::SCWG_BIT_WDOG];
	assign wd_refresh = wr_word && wr_data_i[scwg_pkg::SCWG_BIT_WDOG];

	// trip sticks until the watchdog is disarmed; a late refresh
	// does not restart the drive, the host must disarm first
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wd_cnt <= 32'h00000000;
			wdog_trip_o <= 1'b0;
		end else if (ce_i) begin
			if (!wd_armed) begin
				wd_cnt <= 32'h00000000;
				wdog_trip_o <= 1'b0;
			end else if (wd_refresh) begin
				wd_cnt <= 32'h00000000;
			end else if (wd_cnt >= WDOG_CYCLES - 1) begin
				wdog_trip_o <= 1'b1;
			end else begin
				wd_cnt <= wd_cnt + 32'h00000001;
			end
		end
	end

	// ****************************************************
	// sequencer outputs
	// ****************************************************
	// exactly one direction command wins; else run with direction bit
	assign seq_fwd = (lat_fwd ^ lat_rev) ? lat_fwd : (lat_run && !eff_dir);
	assign seq_rev = (lat_fwd ^ lat_rev) ? lat_rev : (lat_run && eff_dir);
	// running needs enable, stop release and the hardware enable
	assign go_ok = eff_en && eff_ns && pin_s2[scwg_pkg::SCWG_PIN_HWEN]
		&& !wdog_trip_o;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_enable_o <= 1'b0;
			run_fwd_o <= 1'b0;
			run_rev_o <= 1'b0;
			jog_o <= 1'b0;
		end else if (ce_i) begin
			// output stage needs both hardware and command enable
			drive_enable_o <= eff_en && pin_s2[scwg_pkg::SCWG_PIN_HWEN]
				&& !wdog_trip_o;
			run_fwd_o <= go_ok && seq_fwd;
			run_rev_o <= go_ok && seq_rev;
			jog_o <= eff_jog;
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_enable_masked: assert property (
		ce_i && select && mask[0] && !word[0] |=> !drive_enable_o)
		else $error("masked enable zero left drive enabled");
	a_hw_enable: assert property (
		ce_i && !pin_s2[scwg_pkg::SCWG_PIN_HWEN] |=> !drive_enable_o)
		else $error("drive enabled without hardware enable");
	a_stop_release: assert property (
		ce_i && !eff_ns |=> !run_fwd_o && !run_rev_o)
		else $error("drive ran without stop release");
	a_terminal_src: assert property (
		ce_i && !select && !pin_s2[scwg_pkg::SCWG_PIN_EN] |=> !drive_enable_o)
		else $error("terminal enable ignored in terminal mode");
	a_word_ignored: assert property (
		ce_i && !select |=> jog_o == $past(pin_s2[scwg_pkg::SCWG_PIN_JOG]))
		else $error("word used while select is zero");
	a_mask_jog: assert property (
		ce_i && select && mask[2] |=> jog_o == $past(word[2]))
		else $error("masked jog not taken from word");
	a_one_direction: assert property (
		!(run_fwd_o && run_rev_o))
		else $error("forward and reverse both commanded");
	a_dir_select: assert property (
		ce_i && go_ok && lat_run && !lat_fwd && !lat_rev
		|=> run_rev_o == $past(eff_dir) && run_fwd_o == !$past(eff_dir))
		else $error("direction bit not followed");
	a_wdog_stop: assert property (
		ce_i && wdog_trip_o |=> !drive_enable_o && !run_fwd_o && !run_rev_o)
		else $error("watchdog trip did not stop drive");
	a_reserved_zero: assert property (
		(word & ~scwg_pkg::SCWG_WORD_USED) == 15'h0000)
		else $error("reserved word bits stored");

	c_word_fwd: cover property (select && run_fwd_o);
	c_word_rev: cover property (select && run_rev_o);
	c_latched_run: cover property (latch_en && lat_run && !eff_run);
	c_wdog_trip: cover property ($rose(wdog_trip_o));

endmodule

// file: rtl/scwg_pkg.sv
// constants shared by the command word gate and its testbench
// assumes one 40 MHz control clock and a simple parameter write/read port
// Notes on behaviour
// - latching bit makes run commands hold; resets zero
// - word drives only functions whose mask bit set
// - word bits match mask; bits 7-13 reserved
// - mask is volatile, zero after every power-up
// - mask and word ignored unless select equals one
// - select zero means terminals give start/stop/direction
// - run kept but stop-release cleared stops drive
// - direction bit picks forward or reverse when enabled
// - masked enable bit zero disables output stage
// - stop-release command bit is read/write, resets zero
// - fwd/rev first, else run with direction bit
// - inactive stop-release clears all three run latches
// - setting one direction latch clears the other
package scwg_pkg;

	// ****************************************************
	// register indices on the parameter port
	// ****************************************************
	localparam logic [2:0] SCWG_IDX_STOP_REL = 3'h0; // stop-release bit
	localparam logic [2:0] SCWG_IDX_LATCH_EN = 3'h1; // run latch enable
	localparam logic [2:0] SCWG_IDX_MASK = 3'h2; // function mask
	localparam logic [2:0] SCWG_IDX_WORD = 3'h3; // serial command word
	localparam logic [2:0] SCWG_IDX_SELECT = 3'h4; // command source select
	localparam logic [2:0] SCWG_IDX_STATUS = 3'h5; // read-only outputs

	// ****************************************************
	// field layout of mask and command word
	// ****************************************************
	localparam int SCWG_WORD_W = 15;
	localparam int SCWG_BIT_EN = 0;
	localparam int SCWG_BIT_FWD = 1;
	localparam int SCWG_BIT_JOG = 2;
	localparam int SCWG_BIT_REV = 3;
	localparam int SCWG_BIT_DIR = 4;
	localparam int SCWG_BIT_RUN = 5;
	localparam int SCWG_BIT_NSTOP = 6;
	localparam int SCWG_BIT_WDOG = 14;
	// bits 7 to 13 are reserved and always stored as zero
	localparam logic [14:0] SCWG_WORD_USED = 15'h407F;

	// ****************************************************
	// terminal pin vector layout
	// ****************************************************
	localparam int SCWG_PIN_W = 7;
	localparam int SCWG_PIN_EN = 0;
	localparam int SCWG_PIN_FWD = 1;
	localparam int SCWG_PIN_JOG = 2;
	localparam int SCWG_PIN_REV = 3;
	localparam int SCWG_PIN_DIR = 4;
	localparam int SCWG_PIN_RUN = 5;
	localparam int SCWG_PIN_HWEN = 6;

	// ****************************************************
	// reset values and timing
	// ****************************************************
	localparam logic SCWG_RST_BIT = 1'h0;
	localparam logic [14:0] SCWG_RST_WORD = 15'h0000;
	localparam int SCWG_CLK_HZ = 40000000;
	localparam int SCWG_WDOG_MS = 100; // watchdog timeout in ms
	localparam int SCWG_WDOG_CYCLES = SCWG_WDOG_MS * (SCWG_CLK_HZ / 1000);

endpackage

// file: rtl/scwg_run_latch.sv
// three run latches between the command sources and the sequencer
// assumes inputs come from logic on the same clock
`timescale 1ns/1ps
module scwg_run_latch (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic latch_en_i,
	input wire logic not_stop_i,
	input wire logic fwd_i,
	input wire logic rev_i,
	input wire logic run_i,
	output logic fwd_o,
	output logic rev_o,
	output logic run_o
);

	// ****************************************************
	// latches, transparent (one register stage) when disabled
	// ****************************************************
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fwd_o <= 1'b0;
			rev_o <= 1'b0;
			run_o <= 1'b0;
		end else if (ce_i) begin
			if (!not_stop_i) begin
				// stop input drops: every latch let go
				fwd_o <= 1'b0;
				rev_o <= 1'b0;
				run_o <= 1'b0;
			end else if (!latch_en_i) begin
				// transparent path
				fwd_o <= fwd_i;
				rev_o <= rev_i;
				run_o <= run_i;
			end else begin
				// momentary pulses are held until stop, a direction until the opposite one
				run_o <= run_o | run_i;
				if (fwd_i && !rev_i) begin
					fwd_o <= 1'b1;
					rev_o <= 1'b0;
				end else if (rev_i && !fwd_i) begin
					rev_o <= 1'b1;
					fwd_o <= 1'b0;
				end
			end
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	a_latch_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && !not_stop_i |=> !fwd_o && !rev_o && !run_o)
		else $error("run latches not cleared on stop");
	a_latch_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && latch_en_i && not_stop_i && run_o |=> run_o)
		else $error("run latch dropped while latching");
	a_latch_oppose: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ce_i && latch_en_i && not_stop_i && fwd_i && !rev_i
		|=> fwd_o && !rev_o)
		else $error("opposite latch not cleared");

endmodule

// file: verification/scwg_host_model.sv
// serial host model: writes and reads drive parameters on the port
// assumes the gate samples the port on rising mclk_i with ce_i high
`timescale 1ns/1ps
module scwg_host_model (
	input wire logic mclk_i,
	input wire logic [14:0] rd_data_i,
	output logic wr_en_o,
	output logic [2:0] wr_idx_o,
	output logic [14:0] wr_data_o,
	output logic [2:0] rd_idx_o,
	output logic hwen_o
);
	// ****************************************************
	// idle levels at time zero
	// ****************************************************
	initial begin
		wr_en_o = 1'h0;
		wr_idx_o = 3'h0;
		wr_data_o = 15'h0000;
		rd_idx_o = 3'h0;
		hwen_o = 1'h1;
	end

	// one write strobe, raised and dropped on falling edges
	// the whole 15-bit value goes as given; callers may set bits 7-13
	task automatic wr(input logic [2:0] idx, input logic [14:0] data);
		@(negedge mclk_i);
		wr_en_o = 1'h1;
		wr_idx_o = idx;
		wr_data_o = data;
		@(negedge mclk_i);
		wr_en_o = 1'h0;
		wr_data_o = ~data; // stale data must not look valid
	endtask

	// read: index sampled at edge N, data settled by the next fall
	task automatic rd(input logic [2:0] idx, output logic [14:0] data);
		@(negedge mclk_i);
		rd_idx_o = idx;
		@(negedge mclk_i);
		data = rd_data_i;
	endtask

	// installation side hardware enable terminal
	task automatic set_hwen(input logic lvl);
		hwen_o = lvl;
	endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the command word gate
// assumes a 40 MHz clock and a short watchdog parameter for simulation
`timescale 1ns/1ps
module tb;
	logic mclk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic [5:0] pins = 6'h00; // terminal levels except hardware enable
	logic hwen;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [14:0] wr_data;
	logic [2:0] rd_idx;
	logic [14:0] rd_data;
	logic en, fwd, rev, jog, trip;
	logic [14:0] rv;
	int error_cnt = 0;
	int check_count = 0;
	logic ce = 1'h1; // clock enable, dropped once to prove the freeze
	// word sequence of a run/direction/not-stop setup and status replies
	logic [14:0] w2 [5] = '{15'h0061, 15'h0071, 15'h0021, 15'h0000, 15'h0001};
	logic [14:0] s2 [5] = '{15'h0003, 15'h0005, 15'h0001, 15'h0000, 15'h0001};
	// latching sequence: set, release pulse, swap, stop, retry, run pulse
	logic [14:0] w3 [7] = '{15'h0043, 15'h0041, 15'h0049, 15'h0009, 15'h0041,
		15'h0061, 15'h0041};
	logic [14:0] s3 [7] = '{15'h0003, 15'h0003, 15'h0005, 15'h0001, 15'h0001,
		15'h0003, 15'h0003};

	always #12.5 mclk_i = ~mclk_i; // 25 ns period

	// ****************************************************
	// design and host
	// ****************************************************
	scwg_gate #(.WDOG_CYCLES(20)) DUT (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
		.term_pins_i({hwen, pins}), .wr_en_i(wr_en), .wr_idx_i(wr_idx),
		.wr_data_i(wr_data), .rd_idx_i(rd_idx), .rd_data_o(rd_data),
		.drive_enable_o(en), .run_fwd_o(fwd), .run_rev_o(rev),
		.jog_o(jog), .wdog_trip_o(trip)
	);
	scwg_host_model host (
		.mclk_i(mclk_i), .rd_data_i(rd_data), .wr_en_o(wr_en),
		.wr_idx_o(wr_idx), .wr_data_o(wr_data), .rd_idx_o(rd_idx),
		.hwen_o(hwen)
	);

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// outputs packed like the status register
	function automatic logic [14:0] outv();
		return {10'h000, trip, jog, rev, fwd, en};
	endfunction

	// write then let the run latch stage settle before looking
	task automatic wo(input logic [2:0] i, input logic [14:0] d);
		host.wr(i, d);
		cyc(3);
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watchdog against a hang: tests need well under 2000 cycles
	initial begin
		#(25 * 5000);
		error_cnt++;
		end_of_test();
	end

	// ****************************************************
	// tests
	// ****************************************************
	initial begin
		cyc(16);
		rstn_i = 1'h1;
		// reset values of all registers, status and an unmapped index
		for (int i = 0; i < 7; i++) begin
			host.rd(i[2:0], rv);
			chk(rv, 15'h0000);
		end
		chk(outv(), 15'h0000);
		$display("test reset done");

		// register access; reserved bits dropped
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h7FFF);
		host.rd(scwg_pkg::SCWG_IDX_MASK, rv);
		chk(rv, 15'h407F);
		wo(scwg_pkg::SCWG_IDX_STOP_REL, 15'h0001);
		host.rd(scwg_pkg::SCWG_IDX_STOP_REL, rv);
		chk(rv, 15'h0001);
		$display("test registers done");

		// select zero: terminals rule even with mask and word set
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h007F);
		wo(scwg_pkg::SCWG_IDX_WORD, 15'h0000);
		pins = 6'h03;
		cyc(6);
		chk(outv(), 15'h0003);
		pins = 6'h31;
		cyc(6);
		chk(outv(), 15'h0005);
		host.set_hwen(1'h0);
		cyc(6);
		chk(outv() & 15'h0001, 15'h0000);
		host.set_hwen(1'h1);
		pins = 6'h00;
		$display("test terminals done");

		// serial control with run, direction and not-stop masked
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h0071);
		wo(scwg_pkg::SCWG_IDX_SELECT, 15'h0001);
		for (int i = 0; i < 5; i++) begin
			wo(scwg_pkg::SCWG_IDX_WORD, w2[i]);
			chk(outv(), s2[i]);
		end
		$display("test serial run done");

		// unmasked run ignored; masked jog passes; stop bit from register
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h000F);
		wo(scwg_pkg::SCWG_IDX_WORD, 15'h0035);
		chk(outv(), 15'h0009);
		host.rd(scwg_pkg::SCWG_IDX_STATUS, rv);
		chk(rv, 15'h0009);
		wo(scwg_pkg::SCWG_IDX_WORD, 15'h000B);
		chk(outv(), 15'h0001);
		$display("test mask done");

		// latching run inputs
		// run is masked too, so a momentary run pulse must be held
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h006B);
		wo(scwg_pkg::SCWG_IDX_LATCH_EN, 15'h0001);
		for (int i = 0; i < 7; i++) begin
			wo(scwg_pkg::SCWG_IDX_WORD, w3[i]);
			chk(outv(), s3[i]);
		end
		// latches transparent again: the held run drops with its input
		wo(scwg_pkg::SCWG_IDX_LATCH_EN, 15'h0000);
		chk(outv(), 15'h0001);
		$display("test latching done");

		// watchdog: refreshed in time, then starved, then disarmed
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h4071);
		for (int i = 0; i < 3; i++) begin
			host.wr(scwg_pkg::SCWG_IDX_WORD, 15'h4061);
			cyc(8);
			chk(outv(), 15'h0003);
		end
		cyc(40);
		chk(outv(), 15'h0010);
		wo(scwg_pkg::SCWG_IDX_MASK, 15'h0071);
		chk(outv(), 15'h0003);
		$display("test watchdog done");

		// clock enable low: writes and pin changes are frozen out
		ce = 1'h0;
		pins = 6'h04;
		wo(scwg_pkg::SCWG_IDX_SELECT, 15'h0000);
		chk(outv(), 15'h0003);
		ce = 1'h1;
		cyc(4);
		// unmasked jog follows its terminal under serial control
		chk(outv(), 15'h000B);
		host.rd(scwg_pkg::SCWG_IDX_SELECT, rv);
		chk(rv, 15'h0001);
		pins = 6'h00;
		$display("test freeze done");

		// mid-run reset: volatile registers and outputs clear again
		rstn_i = 1'h0;
		cyc(2);
		rstn_i = 1'h1;
		host.rd(scwg_pkg::SCWG_IDX_MASK, rv);
		chk(rv, 15'h0000);
		host.rd(scwg_pkg::SCWG_IDX_SELECT, rv);
		chk(rv, 15'h0000);
		chk(outv(), 15'h0000);
		$display("test power-up done");
		end_of_test();
	end
endmodule
